// ### rtl/clock_source_control.v
// clock source selection, pll stop, sub-oscillator run control, rtc control and flash waits
// assumes apb master on pclk; sleep, wake and supply-drop inputs are synchronous to pclk
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "clock_source_control_consts.vh"
module clock_source_control (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire sleep_mode,
	input wire wake_event,
	input wire supply_drop,
	output wire [2:0] sys_clock_source_select,
	output wire pll_running,
	output wire subosc_running,
	output wire rtc_count_enable,
	output wire [1:0] flash_wait_setting,
	output wire irq
);
	reg [2:0] sys_clock_source_select_reg;
	reg pll_stop_control_reg;
	reg subosc_stop_reg;
	reg [1:0] monitor1_irq_condition_reg;
	reg [1:0] monitor2_irq_condition_reg;
	reg [7:0] sleep_return_clock_control_reg;
	reg [1:0] flash_wait_reg;
	reg [7:0] freq_reg;
	reg [3:0] irq_status_reg;
	reg [3:0] irq_mask_reg;
	reg [31:0] prdata_reg;
	// rtc registers have no reset: they hold across a device reset
	reg rtc_subosc_enable_reg;
	reg [6:0] rtc_three_rest_reg;
	reg rtc_count_source_select_reg;
	reg [6:0] rtc_four_rest_reg;
	reg supply_drop_reg;
	wire wr;
	wire rd;
	wire addr_ok;
	wire wait_ok;
	wire monitor_armed;
	wire drop_event;
	wire wake_switch;
	wire sleep_write;
	wire [3:0] irq_set;
	wire setup_read;
	wire wr_sysclk;
	wire wr_pll;
	wire wr_subosc;
	wire wr_sleep_ret;
	wire wr_flash;
	wire wr_mon1;
	wire wr_mon2;
	wire wr_mask;
	wire wr_status;
	wire wr_freq;
	wire wr_rtc3;
	wire wr_rtc4;
	reg [2:0] sys_clock_source_select_next;
	reg pll_stop_control_next;
	reg [3:0] irq_status_next;
	reg [31:0] prdata_next;

	function is_reg;
		input [11:0] a;
		begin
			is_reg = (a <= `OFS_CLOCK_FREQ_MHZ) && (a[1:0] == 2'h0);
		end
	endfunction

	function is_ofs;
		input [11:0] a;
		input [11:0] ofs;
		begin
			is_ofs = (a == ofs);
		end
	endfunction

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign addr_ok = is_reg(paddr);
	assign pready = 1'b1;
	assign prdata = prdata_reg;
	// combinational so the master sees it at the very edge that ends the access
	assign pslverr = psel && penable && !addr_ok;
	assign setup_read = psel && !penable && !pwrite;
	assign wr_sysclk = wr && is_ofs(paddr, `OFS_SYSTEM_CLOCK_CONTROL);
	assign wr_pll = wr && is_ofs(paddr, `OFS_PLL_CONTROL);
	assign wr_subosc = wr && is_ofs(paddr, `OFS_SUBOSC_CONTROL);
	assign wr_sleep_ret = wr && is_ofs(paddr, `OFS_SLEEP_RETURN_CLOCK_CONTROL);
	assign wr_flash = wr && is_ofs(paddr, `OFS_FLASH_WAIT_SETTING);
	assign wr_mon1 = wr && is_ofs(paddr, `OFS_VOLTAGE_MONITOR1_CONTROL);
	assign wr_mon2 = wr && is_ofs(paddr, `OFS_VOLTAGE_MONITOR2_CONTROL);
	assign wr_mask = wr && is_ofs(paddr, `OFS_IRQ_MASK);
	assign wr_status = wr && is_ofs(paddr, `OFS_IRQ_STATUS);
	assign wr_freq = wr && is_ofs(paddr, `OFS_CLOCK_FREQ_MHZ);
	assign wr_rtc3 = wr && is_ofs(paddr, `OFS_RTC_CONTROL_THREE);
	assign wr_rtc4 = wr && is_ofs(paddr, `OFS_RTC_CONTROL_FOUR);

	assign monitor_armed = (monitor1_irq_condition_reg == `IRQ_COND_DROP) ||
		(monitor2_irq_condition_reg == `IRQ_COND_DROP);
	assign drop_event = monitor_armed && supply_drop && !supply_drop_reg;
	assign wake_switch = wake_event && sleep_mode &&
		sleep_return_clock_control_reg[`RSTCK_EN_BIT];
	// writes to the sleep return clock control register during sleep are dropped and flagged rather than applied
	assign sleep_write = wr && sleep_mode &&
		(paddr == `OFS_SLEEP_RETURN_CLOCK_CONTROL);
	assign irq_set = {sleep_write, !wait_ok, wake_switch, drop_event};

	assign sys_clock_source_select = sys_clock_source_select_reg;
	// pll also kept alive while selected so the core clock never vanishes
	assign pll_running = !pll_stop_control_reg || (sys_clock_source_select_reg == `SYS_CLOCK_SOURCE_SELECT_PLL);
	assign subosc_running = !subosc_stop_reg || rtc_subosc_enable_reg;
	assign rtc_count_enable = rtc_count_source_select_reg ? 1'b1 : subosc_running;
	assign flash_wait_setting = flash_wait_reg;
	assign irq = |(irq_status_reg & irq_mask_reg);

	flash_wait_check u_wait_check (
		.freq_mhz(freq_reg),
		.wait_states(flash_wait_reg),
		.wait_ok(wait_ok)
	);

	// drop beats wake beats a software write of the source select
	always @* begin
		sys_clock_source_select_next = sys_clock_source_select_reg;
		if (drop_event) begin
			sys_clock_source_select_next = `SYS_CLOCK_SOURCE_SELECT_RESET;
		end else if (wake_switch) begin
			sys_clock_source_select_next = sleep_return_clock_control_reg[2:0];
		end else if (wr_sysclk) begin
			sys_clock_source_select_next = pwdata[`SYS_CLOCK_SOURCE_SELECT_MSB:`SYS_CLOCK_SOURCE_SELECT_LSB];
		end
	end

	always @* begin
		pll_stop_control_next = pll_stop_control_reg;
		if (drop_event) begin
			pll_stop_control_next = 1'b1;
		end else if (wr_pll) begin
			pll_stop_control_next = pwdata[0];
		end
	end

	// set wins over write-one-to-clear
	always @* begin
		irq_status_next = irq_status_reg;
		if (wr_status) begin
			irq_status_next = irq_status_reg & ~pwdata[3:0];
		end
		irq_status_next = irq_status_next | irq_set;
	end

	// read data captured in setup so it stands for the whole access phase
	always @* begin
		prdata_next = 32'h00000000;
		if (is_ofs(paddr, `OFS_SYSTEM_CLOCK_CONTROL)) begin
			prdata_next = {21'h0, sys_clock_source_select_reg, 8'h00};
		end else if (is_ofs(paddr, `OFS_PLL_CONTROL)) begin
			prdata_next = {31'h0, pll_stop_control_reg};
		end else if (is_ofs(paddr, `OFS_SUBOSC_CONTROL)) begin
			prdata_next = {31'h0, subosc_stop_reg};
		end else if (is_ofs(paddr, `OFS_RTC_CONTROL_THREE)) begin
			prdata_next = {24'h0, rtc_three_rest_reg, rtc_subosc_enable_reg};
		end else if (is_ofs(paddr, `OFS_RTC_CONTROL_FOUR)) begin
			prdata_next = {24'h0, rtc_four_rest_reg, rtc_count_source_select_reg};
		end else if (is_ofs(paddr, `OFS_SLEEP_RETURN_CLOCK_CONTROL)) begin
			prdata_next = {24'h0, sleep_return_clock_control_reg};
		end else if (is_ofs(paddr, `OFS_FLASH_WAIT_SETTING)) begin
			prdata_next = {30'h0, flash_wait_reg};
		end else if (is_ofs(paddr, `OFS_VOLTAGE_MONITOR1_CONTROL)) begin
			prdata_next = {30'h0, monitor1_irq_condition_reg};
		end else if (is_ofs(paddr, `OFS_VOLTAGE_MONITOR2_CONTROL)) begin
			prdata_next = {30'h0, monitor2_irq_condition_reg};
		end else if (is_ofs(paddr, `OFS_IRQ_STATUS)) begin
			prdata_next = {28'h0, irq_status_reg};
		end else if (is_ofs(paddr, `OFS_IRQ_MASK)) begin
			prdata_next = {28'h0, irq_mask_reg};
		end else if (is_ofs(paddr, `OFS_CLOCK_STATUS)) begin
			prdata_next = {28'h0, wait_ok, rtc_count_enable, subosc_running, pll_running};
		end else if (is_ofs(paddr, `OFS_CLOCK_FREQ_MHZ)) begin
			prdata_next = {24'h0, freq_reg};
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_clock_source_select_reg <= `SYS_CLOCK_SOURCE_SELECT_RESET;
			pll_stop_control_reg <= 1'b1;
			irq_status_reg <= 4'h0;
		end else begin
			sys_clock_source_select_reg <= sys_clock_source_select_next;
			pll_stop_control_reg <= pll_stop_control_next;
			irq_status_reg <= irq_status_next;
		end
	end

	// cleared at reset; a level held across reset is taken in the first cycle after it while both monitors are still disarmed, so it raises no drop edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_drop_reg <= 1'b0;
		end else begin
			supply_drop_reg <= supply_drop;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			subosc_stop_reg <= 1'b0;
		end else if (wr_subosc) begin
			subosc_stop_reg <= pwdata[0];
		end
	end

	// writes during sleep are refused: a wake may be using this register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_return_clock_control_reg <= 8'h00;
		end else if (wr_sleep_ret && !sleep_mode) begin
			sleep_return_clock_control_reg <= pwdata[7:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_wait_reg <= `FLASH_WAIT_RESET;
		end else if (wr_flash) begin
			flash_wait_reg <= pwdata[1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			monitor1_irq_condition_reg <= `IRQ_COND_RESET;
		end else if (wr_mon1) begin
			monitor1_irq_condition_reg <= pwdata[1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			monitor2_irq_condition_reg <= `IRQ_COND_RESET;
		end else if (wr_mon2) begin
			monitor2_irq_condition_reg <= pwdata[1:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= 4'h0;
		end else if (wr_mask) begin
			irq_mask_reg <= pwdata[3:0];
		end
	end

	// frequency is software's word only; nothing measures the real clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_reg <= `FREQ_RESET;
		end else if (wr_freq) begin
			freq_reg <= pwdata[7:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else if (setup_read) begin
			prdata_reg <= prdata_next;
		end
	end

	// no reset on purpose: values survive a device reset
	always @(posedge pclk) begin
		if (wr_rtc3) begin
			rtc_subosc_enable_reg <= pwdata[0];
			rtc_three_rest_reg <= pwdata[7:1];
		end
	end

	always @(posedge pclk) begin
		if (wr_rtc4) begin
			rtc_count_source_select_reg <= pwdata[0];
			rtc_four_rest_reg <= pwdata[7:1];
		end
	end
endmodule
`default_nettype wire

// ### rtl/clock_source_control_consts.vh
// register offsets, field positions, reset values and limits for the clock source control block
// assumes a 32-bit apb slave with word-aligned registers
`ifndef CLOCK_SOURCE_CONTROL_CONSTS_VH
`define CLOCK_SOURCE_CONTROL_CONSTS_VH

`define OFS_SYSTEM_CLOCK_CONTROL 12'h000
`define OFS_PLL_CONTROL 12'h004
`define OFS_SUBOSC_CONTROL 12'h008
`define OFS_RTC_CONTROL_THREE 12'h00C
`define OFS_RTC_CONTROL_FOUR 12'h010
`define OFS_SLEEP_RETURN_CLOCK_CONTROL 12'h014
`define OFS_FLASH_WAIT_SETTING 12'h018
`define OFS_VOLTAGE_MONITOR1_CONTROL 12'h01C
`define OFS_VOLTAGE_MONITOR2_CONTROL 12'h020
`define OFS_IRQ_STATUS 12'h024
`define OFS_IRQ_MASK 12'h028
`define OFS_CLOCK_STATUS 12'h02C
`define OFS_CLOCK_FREQ_MHZ 12'h030

`define SYS_CLOCK_SOURCE_SELECT_PLL 3'h4
`define SYS_CLOCK_SOURCE_SELECT_RESET 3'h0
`define SYS_CLOCK_SOURCE_SELECT_MSB 10
`define SYS_CLOCK_SOURCE_SELECT_LSB 8
`define RSTCK_EN_BIT 7
`define IRQ_COND_DROP 2'h1
`define IRQ_COND_RESET 2'h0
`define FLASH_WAIT_RESET 2'h2
`define FREQ_RESET 8'h08
`define FREQ_LIMIT_LOW 8'h32
`define FREQ_LIMIT_MID 8'h64
`define FREQ_LIMIT_HIGH 8'hC8

`define IRQ_BIT_MONITOR 0
`define IRQ_BIT_WAKE 1
`define IRQ_BIT_WAIT_ERR 2
`define IRQ_BIT_SLEEP_WRITE 3
`define IRQ_WIDTH 4

`endif

// ### rtl/flash_wait_check.v
// checks a flash wait count against the system clock frequency band
// assumes frequency is given in whole megahertz
`timescale 1ns/1ps
`default_nettype none
`include "clock_source_control_consts.vh"
module flash_wait_check (
	input wire [7:0] freq_mhz,
	input wire [1:0] wait_states,
	output wire wait_ok
);
	reg ok;
	always @* begin
		if (freq_mhz <= `FREQ_LIMIT_LOW) begin
			ok = (wait_states <= 2'h2);
		end else if (freq_mhz <= `FREQ_LIMIT_MID) begin
			ok = (wait_states == 2'h1) || (wait_states == 2'h2);
		end else if (freq_mhz <= `FREQ_LIMIT_HIGH) begin
			ok = (wait_states == 2'h2);
		end else begin
			ok = 1'b0;
		end
	end
	assign wait_ok = ok;
endmodule
`default_nettype wire

// ### testbench/clock_source_control_assertions.sv
// port checker for the clock source control block
// assumes binding onto clock_source_control, one pclk domain
`timescale 1ns/1ps
`default_nettype none
`include "clock_source_control_consts.vh"
module clock_source_control_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sleep_mode,
	input wire logic wake_event,
	input wire logic supply_drop,
	input wire logic [2:0] sys_clock_source_select,
	input wire logic pll_running,
	input wire logic subosc_running,
	input wire logic rtc_count_enable,
	input wire logic [1:0] flash_wait_setting,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr = psel && penable && pwrite;
	wire bad = paddr > 12'h030 || paddr[1:0] != 2'h0;
	chk_ready_high: assert property (pready) else $error("pready low");
	chk_slverr_map: assert property (psel && penable |-> pslverr == bad) else $error("pslverr");
	chk_pll_select: assert property (sys_clock_source_select == 3'h4 |-> pll_running)
		else $error("pll off while selected");
	chk_pll_stop: assert property (wr && paddr == `OFS_PLL_CONTROL && pwdata[0] &&
		sys_clock_source_select != 3'h4 && !wake_event |=> !pll_running) else $error("pll on");
	chk_subosc_run: assert property (wr && (paddr == `OFS_SUBOSC_CONTROL && !pwdata[0] ||
		paddr == `OFS_RTC_CONTROL_THREE && pwdata[0]) |=> subosc_running) else $error("subosc");
	chk_count_source: assert property (wr && paddr == `OFS_RTC_CONTROL_FOUR && pwdata[0]
		|=> rtc_count_enable) else $error("count enable");
	chk_select_hold: assert property (!(wr && paddr == `OFS_SYSTEM_CLOCK_CONTROL) &&
		!$rose(supply_drop) && !wake_event |=> $stable(sys_clock_source_select)) else $error("sel");
	chk_wait_reset: assert property ($rose(presetn) |-> flash_wait_setting == 2'h2)
		else $error("wait reset");
	chk_wait_hold: assert property (!(wr && paddr == `OFS_FLASH_WAIT_SETTING)
		|=> $stable(flash_wait_setting)) else $error("wait changed");
	cover property ($rose(supply_drop));
	cover property (wake_event && sleep_mode);
	cover property ($rose(irq));
endmodule
bind clock_source_control clock_source_control_assertions chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.sleep_mode(sleep_mode),
	.wake_event(wake_event),
	.supply_drop(supply_drop),
	.sys_clock_source_select(sys_clock_source_select),
	.pll_running(pll_running),
	.subosc_running(subosc_running),
	.rtc_count_enable(rtc_count_enable),
	.flash_wait_setting(flash_wait_setting),
	.irq(irq)
);
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the clock source control block
// assumes zero or more apb wait states, one pclk domain
`timescale 1ns/1ps
`default_nettype none
`include "clock_source_control_consts.vh"
module tb_top;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic sleep_mode = 1'h0, wake_event = 1'h0, supply_drop = 1'h0, er;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rd, d, seed = 32'h282EC6B7;
	logic [7:0] fq [7] = '{8'h32, 8'h33, 8'h64, 8'h65, 8'hC8, 8'hC9, 8'h32};
	logic [1:0] wt [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
	wire [31:0] prdata;
	wire pready, pslverr, pll_running, subosc_running, rtc_count_enable, irq;
	wire [2:0] sys_clock_source_select;
	wire [1:0] flash_wait_setting;
	integer fail_count = 0, n_checks = 0, k;
	clock_source_control uut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.sleep_mode(sleep_mode),
		.wake_event(wake_event),
		.supply_drop(supply_drop),
		.sys_clock_source_select(sys_clock_source_select),
		.pll_running(pll_running),
		.subosc_running(subosc_running),
		.rtc_count_enable(rtc_count_enable),
		.flash_wait_setting(flash_wait_setting),
		.irq(irq)
	);
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic wok(input logic [7:0] f, input logic [1:0] w);
		if (f <= 8'h32) return w != 2'h3;
		if (f <= 8'h64) return w == 2'h1 || w == 2'h2;
		return f <= 8'hC8 && w == 2'h2;
	endfunction
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task ck(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one idle cycle between transfers keeps each signal to one assignment per step
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
		integer i;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'h1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'h1 && i < 50);
		ck("pready", 1, pready);
		if (pready !== 1'h1) close_out;
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e);
		xfer(1'h0, a, 32'h0);
		ck("read", e, rd);
	endtask
	initial begin
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		d = (rnd() & 32'hFE) | 32'h1;
		xfer(1'h1, `OFS_RTC_CONTROL_THREE, d);
		xfer(1'h1, `OFS_RTC_CONTROL_FOUR, 32'h0);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		rc(`OFS_RTC_CONTROL_THREE, d);
		rc(`OFS_PLL_CONTROL, 32'h1);
		rc(`OFS_SYSTEM_CLOCK_CONTROL, 32'h0);
		rc(`OFS_FLASH_WAIT_SETTING, 32'h2);
		for (k = 0; k < 8; k++) begin
			xfer(1'h1, `OFS_SUBOSC_CONTROL, k & 1);
			xfer(1'h1, `OFS_RTC_CONTROL_THREE, k >> 1);
			xfer(1'h1, `OFS_RTC_CONTROL_FOUR, k >> 2);
			@(negedge pclk);
			ck("subosc", !k[0] || k[1], subosc_running);
			ck("count", k[2] || !k[0] || k[1], rtc_count_enable);
		end
		xfer(1'h1, `OFS_PLL_CONTROL, 32'h0);
		@(negedge pclk);
		ck("pll run", 1, pll_running);
		xfer(1'h1, `OFS_PLL_CONTROL, 32'h1);
		@(negedge pclk);
		ck("pll stop", 0, pll_running);
		for (k = 0; k < 8; k++) begin
			xfer(1'h1, `OFS_SYSTEM_CLOCK_CONTROL, (rnd() & 32'hFFFFF8FF) | (k << 8));
			@(negedge pclk);
			ck("select", k, sys_clock_source_select);
			ck("pll", k == 4, pll_running);
		end
		xfer(1'h1, `OFS_VOLTAGE_MONITOR1_CONTROL, 32'h1);
		xfer(1'h1, `OFS_IRQ_MASK, 32'hF);
		xfer(1'h1, `OFS_SYSTEM_CLOCK_CONTROL, 32'h400);
		supply_drop <= 1'h1;
		@(posedge pclk);
		@(negedge pclk);
		ck("drop select", 0, sys_clock_source_select);
		ck("drop pll", 0, pll_running);
		ck("irq", 1, irq);
		rc(`OFS_IRQ_STATUS, 32'h1);
		xfer(1'h1, `OFS_IRQ_STATUS, 32'h1);
		@(negedge pclk);
		ck("irq", 0, irq);
		xfer(1'h1, `OFS_SLEEP_RETURN_CLOCK_CONTROL, 32'h84);
		sleep_mode <= 1'h1;
		xfer(1'h1, `OFS_SLEEP_RETURN_CLOCK_CONTROL, 32'h80);
		wake_event <= 1'h1;
		@(posedge pclk);
		wake_event <= 1'h0;
		sleep_mode <= 1'h0;
		@(negedge pclk);
		ck("wake select", 4, sys_clock_source_select);
		rc(`OFS_SLEEP_RETURN_CLOCK_CONTROL, 32'h84);
		rc(`OFS_IRQ_STATUS, 32'hA);
		for (k = 0; k < 7; k++) begin
			xfer(1'h1, `OFS_CLOCK_FREQ_MHZ, fq[k]);
			xfer(1'h1, `OFS_FLASH_WAIT_SETTING, wt[k]);
			xfer(1'h0, `OFS_CLOCK_STATUS, 32'h0);
			ck("wait ok", wok(fq[k], wt[k]), rd[3]);
			ck("wait", wt[k], flash_wait_setting);
		end
		rc(12'h034, 32'h0);
		ck("slverr", 1, er);
		close_out;
	end
endmodule
`default_nettype wire
